//--- hw/tefl_flags.sv
// Purpose: sticky event flags for the two 16-bit timers, with vector and write-one clears
// Assumes: timer clock events arrive as one-cycle tick-qualified strobes; inputs synchronous to sys_clk_i
// Notes:   set beats clear in the same cycle so no event is lost
// Notes on behaviour
// - t1 capture pin event sets t1 capture flag
// - t1 capture-as-top mode: top reach sets flag
// - t1 capture flag cleared by vector or one
// - t1 compare A match sets flag next tick
// - t1 compare B match sets flag next tick
// - t1 compare C match sets flag next tick
// - t3 compare A match sets flag next tick
// - t3 compare B match sets flag next tick
// - t3 compare C match sets flag next tick
// - force compare strobes never set compare flags
// - compare flags cleared by vector or one
// - t1 overflow in normal/clear-on-match sets flag
// - t3 overflow in normal/clear-on-match sets flag
// - overflow flags cleared by vector or one
// - t3 capture pin event sets t3 capture flag
// - t3 capture-as-top mode: top reach sets flag
// - t3 capture flag cleared by vector or one
// - request only when masked on and global enable
module tefl_flags (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    // timer clock qualifier: one cycle per timer tick
    input  wire logic        t1_tick_i,
    input  wire logic        t3_tick_i,
    // counter and compare values, one set per 16-bit timer
    input  wire logic [15:0] t1_counter_i,
    input  wire logic [15:0] t1_compare_a_i,
    input  wire logic [15:0] t1_compare_b_i,
    input  wire logic [15:0] t1_compare_c_i,
    input  wire logic [15:0] t3_counter_i,
    input  wire logic [15:0] t3_compare_a_i,
    input  wire logic [15:0] t3_compare_b_i,
    input  wire logic [15:0] t3_compare_c_i,
    // force strobes drive the waveform side only
    input  wire logic        t1_force_cmp_a_i,
    input  wire logic        t1_force_cmp_b_i,
    input  wire logic        t1_force_cmp_c_i,
    input  wire logic        t3_force_cmp_a_i,
    input  wire logic        t3_force_cmp_b_i,
    input  wire logic        t3_force_cmp_c_i,
    // capture pin events need no tick, top and overflow points are tick-qualified
    input  wire logic        t1_capture_event_i,
    input  wire logic        t3_capture_event_i,
    input  wire logic        t1_capture_is_top_i,
    input  wire logic        t3_capture_is_top_i,
    input  wire logic        t1_top_reached_i,
    input  wire logic        t3_top_reached_i,
    input  wire logic        t1_overflow_i,
    input  wire logic        t3_overflow_i,
    input  wire logic        t1_mode_overflow_i,
    input  wire logic        t3_mode_overflow_i,
    // high in normal and clear-on-match modes, where the wrap is the overflow point
    input  wire logic        t1_normal_or_match_clr_i,
    input  wire logic        t3_normal_or_match_clr_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // interrupt side
    input  wire logic [9:0]  irq_mask_i,
    input  wire logic        global_irq_en_i,
    input  wire logic [9:0]  vector_ack_i,
    output logic      [9:0]  irq_req_o,
    output logic      [9:0]  flags_o
);
    logic [9:0] flag;
    logic [9:0] set_ev;
    logic [9:0] sw_clr;
    logic [9:0] next_flag;
    logic [9:0] cmp_match;
    logic [9:0] cmp_pend;
    logic       wr_shared;
    logic       wr_ext;
    logic [7:0] rd_shared;
    logic [7:0] rd_ext;
    logic [7:0] next_rdata;
    logic [9:0] flag_tick;

    // raw equality, force strobes deliberately play no part here
    assign cmp_match[tefl_pkg::F_T1_CMP_A] = (t1_counter_i == t1_compare_a_i);
    assign cmp_match[tefl_pkg::F_T1_CMP_B] = (t1_counter_i == t1_compare_b_i);
    assign cmp_match[tefl_pkg::F_T1_CMP_C] = (t1_counter_i == t1_compare_c_i);
    assign cmp_match[tefl_pkg::F_T3_CMP_A] = (t3_counter_i == t3_compare_a_i);
    assign cmp_match[tefl_pkg::F_T3_CMP_B] = (t3_counter_i == t3_compare_b_i);
    assign cmp_match[tefl_pkg::F_T3_CMP_C] = (t3_counter_i == t3_compare_c_i);
    assign cmp_match[tefl_pkg::F_T1_CAP]   = 1'b0;
    assign cmp_match[tefl_pkg::F_T1_OVF]   = 1'b0;
    assign cmp_match[tefl_pkg::F_T3_CAP]   = 1'b0;
    assign cmp_match[tefl_pkg::F_T3_OVF]   = 1'b0;

    // force strobes only feed the waveform side, unused by flags
    logic unused_force;
    assign unused_force = t1_force_cmp_a_i | t1_force_cmp_b_i | t1_force_cmp_c_i |
                          t3_force_cmp_a_i | t3_force_cmp_b_i | t3_force_cmp_c_i;

    // set events; compare flags come from the match seen on the previous tick
    assign set_ev[tefl_pkg::F_T1_CAP]   = t1_capture_is_top_i ? (t1_top_reached_i & t1_tick_i)
                                                              : t1_capture_event_i;
    assign set_ev[tefl_pkg::F_T3_CAP]   = t3_capture_is_top_i ? (t3_top_reached_i & t3_tick_i)
                                                              : t3_capture_event_i;
    assign set_ev[tefl_pkg::F_T1_CMP_A] = cmp_pend[tefl_pkg::F_T1_CMP_A] & t1_tick_i;
    assign set_ev[tefl_pkg::F_T1_CMP_B] = cmp_pend[tefl_pkg::F_T1_CMP_B] & t1_tick_i;
    assign set_ev[tefl_pkg::F_T1_CMP_C] = cmp_pend[tefl_pkg::F_T1_CMP_C] & t1_tick_i;
    assign set_ev[tefl_pkg::F_T3_CMP_A] = cmp_pend[tefl_pkg::F_T3_CMP_A] & t3_tick_i;
    assign set_ev[tefl_pkg::F_T3_CMP_B] = cmp_pend[tefl_pkg::F_T3_CMP_B] & t3_tick_i;
    assign set_ev[tefl_pkg::F_T3_CMP_C] = cmp_pend[tefl_pkg::F_T3_CMP_C] & t3_tick_i;
    // overflow point: wrap in normal/ctc, else the mode-specific point from the core
    assign set_ev[tefl_pkg::F_T1_OVF]   = t1_tick_i & (t1_normal_or_match_clr_i ? t1_overflow_i
                                                       : t1_mode_overflow_i);
    assign set_ev[tefl_pkg::F_T3_OVF]   = t3_tick_i & (t3_normal_or_match_clr_i ? t3_overflow_i
                                                       : t3_mode_overflow_i);

    // write-one-to-clear decode; zeros leave flags alone
    assign wr_shared = reg_wr_i & (reg_addr_i == tefl_pkg::SHARED_FLAGS_OFFSET);
    assign wr_ext    = reg_wr_i & (reg_addr_i == tefl_pkg::EXTENDED_FLAGS_OFFSET);
    assign sw_clr[tefl_pkg::F_T1_CAP]   = wr_shared & reg_wdata_i[tefl_pkg::SH_T1_CAPTURE];
    assign sw_clr[tefl_pkg::F_T1_CMP_A] = wr_shared & reg_wdata_i[tefl_pkg::SH_T1_CMP_A];
    assign sw_clr[tefl_pkg::F_T1_CMP_B] = wr_shared & reg_wdata_i[tefl_pkg::SH_T1_CMP_B];
    assign sw_clr[tefl_pkg::F_T1_OVF]   = wr_shared & reg_wdata_i[tefl_pkg::SH_T1_OVERFLOW];
    assign sw_clr[tefl_pkg::F_T1_CMP_C] = wr_ext & reg_wdata_i[tefl_pkg::EX_T1_CMP_C];
    assign sw_clr[tefl_pkg::F_T3_CAP]   = wr_ext & reg_wdata_i[tefl_pkg::EX_T3_CAPTURE];
    assign sw_clr[tefl_pkg::F_T3_CMP_A] = wr_ext & reg_wdata_i[tefl_pkg::EX_T3_CMP_A];
    assign sw_clr[tefl_pkg::F_T3_CMP_B] = wr_ext & reg_wdata_i[tefl_pkg::EX_T3_CMP_B];
    assign sw_clr[tefl_pkg::F_T3_CMP_C] = wr_ext & reg_wdata_i[tefl_pkg::EX_T3_CMP_C];
    assign sw_clr[tefl_pkg::F_T3_OVF]   = wr_ext & reg_wdata_i[tefl_pkg::EX_T3_OVERFLOW];

    // flag vector order, shared with irq_mask_i, vector_ack_i and irq_req_o:
    //   0 t1 capture, 1 t1 compare a, 2 t1 compare b, 3 t1 compare c, 4 t1 overflow
    //   5 t3 capture, 6 t3 compare a, 7 t3 compare b, 8 t3 compare c, 9 t3 overflow
    // a vector ack and a write-one clear in one cycle simply clear the flag;
    // a set event in that cycle still wins, so an event that lands while software
    // clears is never lost and the flag, and with it the request, stays up without a gap
    genvar gi;
    generate
        for (gi = 0; gi < tefl_pkg::NUM_FLAGS; gi = gi + 1) begin : g_flag
            assign next_flag[gi] = set_ev[gi] |
                                   (flag[gi] & ~(sw_clr[gi] | vector_ack_i[gi]));
            assign irq_req_o[gi] = flag[gi] & irq_mask_i[gi] & global_irq_en_i;
        end
    endgenerate

    // timer tick seen by each flag: bits 4:0 belong to timer 1, bits 9:5 to timer 3
    assign flag_tick = {{5{t3_tick_i}}, {5{t1_tick_i}}};

    // match pending holds the equality until the next tick of its own timer samples it;
    // bits without a comparator stay zero because their match input is tied low
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cmp_pend <= 10'h000;
        end else if (clk_en_i) begin
            cmp_pend <= (flag_tick & cmp_match) | (~flag_tick & cmp_pend);
        end
    end

    // flag state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            flag <= 10'h000;
        end else if (clk_en_i) begin
            flag <= next_flag;
        end
    end

    // shared register: 5 t1 capture, 4 t1 compare a, 3 t1 compare b, 2 t1 overflow;
    // its bits 7:6 and 1:0 belong to other timers and read zero from this block,
    // so the bus side must merge them with the other timers' own flags
    // extended register: 5 t3 capture, 4 t3 a, 3 t3 b, 2 t3 overflow, 1 t3 c, 0 t1 c
    // read mux; unowned and unused bits read zero
    assign rd_shared = {2'h0, flag[tefl_pkg::F_T1_CAP], flag[tefl_pkg::F_T1_CMP_A],
                        flag[tefl_pkg::F_T1_CMP_B], flag[tefl_pkg::F_T1_OVF], 2'h0};
    assign rd_ext    = {2'h0, flag[tefl_pkg::F_T3_CAP], flag[tefl_pkg::F_T3_CMP_A], flag[tefl_pkg::F_T3_CMP_B],
                        flag[tefl_pkg::F_T3_OVF], flag[tefl_pkg::F_T3_CMP_C], flag[tefl_pkg::F_T1_CMP_C]};
    assign next_rdata = (reg_addr_i == tefl_pkg::SHARED_FLAGS_OFFSET)   ? (rd_shared & tefl_pkg::SHARED_OWNED_MASK) :
                        (reg_addr_i == tefl_pkg::EXTENDED_FLAGS_OFFSET) ? (rd_ext & tefl_pkg::EXTENDED_OWNED_MASK) :
                        8'h00;

    // registered read data, one cycle after the address
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= tefl_pkg::SHARED_FLAGS_RESET;
        end else if (clk_en_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    assign flags_o = flag;
endmodule

//--- hw/tefl_pkg.sv
// Purpose: constants shared by the timer event flag logic
// Assumes: 8-bit register port, offsets are the device's own register addresses
// Notes:   only the timer-1 and timer-3 flag bits live in this block
package tefl_pkg;
    localparam logic [7:0] SHARED_FLAGS_OFFSET   = 8'h36; // io space address of the shared flag register
    localparam logic [7:0] EXTENDED_FLAGS_OFFSET = 8'h7c;
    localparam logic [7:0] SHARED_FLAGS_RESET    = 8'h00;
    localparam logic [7:0] EXTENDED_FLAGS_RESET  = 8'h00;
    // shared flag register fields
    localparam int SH_T1_CAPTURE  = 5;
    localparam int SH_T1_CMP_A    = 4;
    localparam int SH_T1_CMP_B    = 3;
    localparam int SH_T1_OVERFLOW = 2;
    // extended flag register fields
    localparam int EX_T3_CAPTURE  = 5;
    localparam int EX_T3_CMP_A    = 4;
    localparam int EX_T3_CMP_B    = 3;
    localparam int EX_T3_OVERFLOW = 2;
    localparam int EX_T3_CMP_C    = 1;
    localparam int EX_T1_CMP_C    = 0;
    // bits of the shared register owned by this block, others read zero here
    localparam logic [7:0] SHARED_OWNED_MASK   = 8'h3c;
    localparam logic [7:0] EXTENDED_OWNED_MASK = 8'h3f;
    // flag index order used by the per-flag generate loop
    localparam int NUM_FLAGS   = 10;
    localparam int F_T1_CAP    = 0;
    localparam int F_T1_CMP_A  = 1;
    localparam int F_T1_CMP_B  = 2;
    localparam int F_T1_CMP_C  = 3;
    localparam int F_T1_OVF    = 4;
    localparam int F_T3_CAP    = 5;
    localparam int F_T3_CMP_A  = 6;
    localparam int F_T3_CMP_B  = 7;
    localparam int F_T3_CMP_C  = 8;
    localparam int F_T3_OVF    = 9;
endpackage

//--- bench/tefl_properties.sv
// Purpose: property checks for the timer event flag block
// Assumes: bound to tefl_flags, one clock domain
// Notes:   set beats clear, so clear checks leave out same-cycle set sources
module tefl_properties (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        clk_en_i,
    input wire logic        t1_tick_i,
    input wire logic        t3_tick_i,
    input wire logic        t1_capture_event_i,
    input wire logic        t1_capture_is_top_i,
    input wire logic        t3_capture_is_top_i,
    input wire logic        t3_top_reached_i,
    input wire logic        t1_overflow_i,
    input wire logic        t1_normal_or_match_clr_i,
    input wire logic        t3_mode_overflow_i,
    input wire logic        t3_normal_or_match_clr_i,
    input wire logic        global_irq_en_i,
    input wire logic        reg_wr_i,
    input wire logic [15:0] t1_counter_i,
    input wire logic [15:0] t1_compare_a_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [9:0]  irq_mask_i,
    input wire logic [9:0]  vector_ack_i,
    input wire logic [9:0]  irq_req_o,
    input wire logic [9:0]  flags_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic pend_a;
    wire  ex_wr = clk_en_i && reg_wr_i && reg_addr_i == tefl_pkg::EXTENDED_FLAGS_OFFSET;
    // match seen on one tick, flag due on the next
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) pend_a <= 1'b0;
        else if (clk_en_i && t1_tick_i) pend_a <= t1_counter_i == t1_compare_a_i;
    end
    a_irq_gating: assert property (irq_req_o == (flags_o & irq_mask_i & {10{global_irq_en_i}}))
        else $error("irq request does not follow flag, mask and enable");
    a_cap_pin_set: assert property (clk_en_i && t1_capture_event_i && !t1_capture_is_top_i |=> flags_o[0])
        else $error("capture event did not set flag");
    a_t3_top_set: assert property (clk_en_i && t3_tick_i && t3_capture_is_top_i && t3_top_reached_i
                                   |=> flags_o[5])
        else $error("top reach did not set t3 capture flag");
    a_cmp_a_next: assert property (clk_en_i && t1_tick_i && pend_a |=> flags_o[1])
        else $error("compare flag not set on following tick");
    a_cmp_a_cause: assert property ($rose(flags_o[1]) |-> $past(clk_en_i && t1_tick_i && pend_a))
        else $error("compare flag set without a match");
    a_t1_ovf_set: assert property (clk_en_i && t1_tick_i && t1_normal_or_match_clr_i && t1_overflow_i
                                   |=> flags_o[4])
        else $error("overflow did not set flag");
    a_t3_mode_ovf: assert property (clk_en_i && t3_tick_i && !t3_normal_or_match_clr_i && t3_mode_overflow_i
                                    |=> flags_o[9])
        else $error("mode overflow did not set flag");
    a_ack_clears: assert property (clk_en_i && vector_ack_i[0] && !t1_capture_event_i && !t1_tick_i
                                   |=> !flags_o[0])
        else $error("vector ack did not clear flag");
    a_wr1_clear: assert property (ex_wr && reg_wdata_i[2] && !t3_tick_i |=> !flags_o[9])
        else $error("write one did not clear flag");
    a_freeze_hold: assert property (!clk_en_i |=> $stable(flags_o))
        else $error("flags moved while frozen");
    a_rsvd_zero: assert property (clk_en_i && reg_addr_i == tefl_pkg::EXTENDED_FLAGS_OFFSET
                                  |=> reg_rdata_o[7:6] == 2'b00)
        else $error("unused bits read nonzero");
    c_cmp_set: cover property ($rose(flags_o[1]));
    c_ack: cover property (vector_ack_i != 10'h000);
    c_mode_ovf: cover property ($rose(flags_o[9]));
endmodule

//--- bench/tefl_cpu_model.sv
// Purpose: core interrupt logic in front of the flag block
// Assumes: one vector runs at a time, lowest index first
// Notes:   delay lets the bench see a request before it is served
module tefl_cpu_model #(parameter int DELAY = 2) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [9:0] req_i,
    output logic      [9:0] ack_o = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // a vector only runs while its request is up, and its run clears the flag
    always @(posedge clk_i) begin
        ack_o <= '0;
        if (rst_i || req_i == '0 || ack_o != '0) cnt <= 0;
        else if (cnt == DELAY) ack_o <= req_i & (~req_i + 10'h001);
        else cnt <= cnt + 1;
    end
endmodule

//--- bench/tefl_flags_tb.sv
// Purpose: self-checking bench for the timer event flag block
// Assumes: inputs move on the falling edge, cpu model serves requests
// Notes:   force strobes stay high all run, so no compare flag may owe anything to them
module tefl_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SH = tefl_pkg::SHARED_FLAGS_OFFSET;
    localparam logic [7:0] EX = tefl_pkg::EXTENDED_FLAGS_OFFSET;
    logic sys_clk_i = 0, rst_i = 1, clk_en_i = 1, t1_tick_i = 0, t3_tick_i = 0, reg_wr_i = 0, global_irq_en_i = 0;
    logic t1_force_cmp_a_i = 1, t1_force_cmp_b_i = 1, t1_force_cmp_c_i = 1;
    logic t3_force_cmp_a_i = 1, t3_force_cmp_b_i = 1, t3_force_cmp_c_i = 1;
    logic t1_capture_event_i = 0, t3_capture_event_i = 0, t1_capture_is_top_i = 0, t3_capture_is_top_i = 0;
    logic t1_top_reached_i = 0, t3_top_reached_i = 0, t1_overflow_i = 0, t3_overflow_i = 0;
    logic t1_mode_overflow_i = 0, t3_mode_overflow_i = 0;
    logic t1_normal_or_match_clr_i = 0, t3_normal_or_match_clr_i = 0;
    logic [15:0] t1_counter_i = 16'h0123, t3_counter_i = 16'h0123;
    logic [15:0] t1_compare_a_i = 16'h0200, t1_compare_b_i = 16'h0200, t1_compare_c_i = 16'h0200;
    logic [15:0] t3_compare_a_i = 16'h0200, t3_compare_b_i = 16'h0200, t3_compare_c_i = 16'h0200;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [9:0]  irq_mask_i = 10'h000, vector_ack_i, irq_req_o, flags_o;
    int err_total = 0, total_checks = 0;
    tefl_flags tefl_flags_i (.*);
    tefl_cpu_model #(.DELAY(2)) tefl_cpu_model_i (.clk_i(sys_clk_i), .rst_i(rst_i),
                                                  .req_i(irq_req_o), .ack_o(vector_ack_i));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic tick(logic a, logic b);
        t1_tick_i = a;
        t3_tick_i = b;
        cyc(1);
        t1_tick_i = 0;
        t3_tick_i = 0;
        cyc(1);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        cyc(1);
        reg_wr_i = 0;
        cyc(1);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_addr_i = a;
        cyc(1);
        chk("rdata", {2'b00, e}, {2'b00, reg_rdata_o});
    endtask
    // all six compare channels: match tick arms, next tick sets, then clear with ones and zeros
    task automatic sc_compare();
        tick(1, 1);
        chk("flags", 10'h000, flags_o);
        {t1_compare_a_i, t1_compare_b_i, t1_compare_c_i} = {3{16'h0123}};
        {t3_compare_a_i, t3_compare_b_i, t3_compare_c_i} = {3{16'h0123}};
        tick(1, 1);
        chk("flags", 10'h000, flags_o);
        t1_counter_i = 16'h0124;
        t3_counter_i = 16'h0124;
        tick(1, 1);
        chk("flags", 10'h1ce, flags_o);
        rd(SH, 8'h18);
        rd(EX, 8'h1b);
        wr(EX, 8'h16);
        wr(SH, 8'hc3);
        chk("flags", 10'h08e, flags_o);
        rd(EX, 8'h09);
    endtask
    // wrap overflow only counts in normal modes; capture by top and pin, overflow by mode point
    task automatic sc_events();
        t1_overflow_i = 1;
        t3_capture_is_top_i = 1;
        t3_top_reached_i = 1;
        t3_mode_overflow_i = 1;
        tick(1, 1);
        chk("flags", 10'h2ae, flags_o);
        t1_normal_or_match_clr_i = 1;
        t1_capture_event_i = 1;
        cyc(1);
        t1_capture_event_i = 0;
        tick(1, 0);
        chk("flags", 10'h2bf, flags_o);
    endtask
    // masked requests, then the model's vectors drain every flag
    task automatic sc_irq();
        irq_mask_i = 10'h3fe;
        cyc(1);
        chk("irq", 10'h000, irq_req_o);
        global_irq_en_i = 1;
        cyc(1);
        chk("irq", 10'h2be, irq_req_o);
        irq_mask_i = 10'h3ff;
        for (int i = 0; i < 60 && flags_o !== 10'h000; i++) cyc(1);
        chk("flags", 10'h000, flags_o);
        global_irq_en_i = 0;
        clk_en_i = 0;
        t1_capture_event_i = 1;
        cyc(1);
        t1_capture_event_i = 0;
        clk_en_i = 1;
        cyc(1);
        chk("flags", 10'h000, flags_o);
    endtask
    // t1 top reach, t3 pin capture and t3 normal overflow
    task automatic sc_second();
        {t1_overflow_i, t3_capture_is_top_i, t3_mode_overflow_i} = 3'h0;
        {t1_capture_is_top_i, t1_top_reached_i, t3_normal_or_match_clr_i, t3_overflow_i} = 4'hf;
        t3_capture_event_i = 1;
        tick(1, 1);
        t3_capture_event_i = 0;
        chk("flags", 10'h221, flags_o);
    endtask
    initial begin
        #100000;
        err_total++;
        summarize();
    end
    initial begin
        cyc(5);
        rst_i = 0;
        cyc(1);
        chk("flags", 10'h000, flags_o);
        rd(SH, 8'h00);
        rd(EX, 8'h00);
        sc_compare();
        sc_events();
        sc_irq();
        sc_second();
        summarize();
    end
endmodule
bind tefl_flags tefl_properties tefl_properties_i (.*);
